// *** rtl/cts_cfg.svh ***
`ifndef CTS_CFG_SVH
`define CTS_CFG_SVH

// ==========================================================
// Register map (device register addresses)
`define CTS_ADDR_FAULT      8'h0d
`define CTS_ADDR_TERMCFG    8'h11

// ==========================================================
// Configuration register fields and reset value
`define CTS_TERMCFG_RESET   8'h40
`define CTS_CODE_MSB        7
`define CTS_CODE_LSB        5
`define CTS_BIT_DIV20       4
`define CTS_BIT_DIV10       3
`define CTS_BIT_DIV5        2
`define CTS_MODE_MSB        1
`define CTS_MODE_LSB        0

// ==========================================================
// Fault register fields
`define CTS_BIT_UPPER_OT    0

// ==========================================================
// Currents, in units of 0.1 mA
`define CTS_TERM_MIN        16'd125
`define CTS_TERM_MAX        16'd1700
`define CTS_TERM_C0         16'd125
`define CTS_TERM_C1         16'd325
`define CTS_TERM_C2         16'd525
`define CTS_TERM_C3         16'd725
`define CTS_TERM_C4         16'd925
`define CTS_TERM_C5         16'd1175
`define CTS_TERM_C6         16'd1425
`define CTS_TERM_C7         16'd1700
`define CTS_DIV20           16'd20
`define CTS_DIV10           16'd10
`define CTS_DIV5            16'd5
// Fast charge code to current: base plus code times step
`define CTS_ICHG_BASE       16'd500
`define CTS_ICHG_STEP       16'd500

`endif

// *** rtl/cts_pkg.sv ***
package cts_pkg;

    // ==========================================================
    // System-enable modes
    typedef enum logic [1:0] {
        CTS_SYSEN_LDO_OK,
        CTS_SYSEN_BATT_NODE,
        CTS_SYSEN_WEAK_ISO,
        CTS_SYSEN_LDO_OR_WEAK
    } cts_sysen_mode_t;

    // ==========================================================
    // Thermal state
    typedef enum logic {
        CTS_THERM_RUN,
        CTS_THERM_SHUTDOWN
    } cts_therm_state_t;

endpackage : cts_pkg

// *** rtl/cts_term_calc.sv ***
`timescale 1ns/100ps
`include "cts_cfg.svh"

module cts_term_calc (
    // Configuration fields
    input  wire logic [2:0]  termCurrentCode,
    input  wire logic        ratioDiv20,
    input  wire logic        ratioDiv10,
    input  wire logic        ratioDiv5,
    // Programmed charge current
    input  wire logic [4:0]  fastChargeCurrentCode,
    // Resulting end-of-charge current, 0.1 mA units
    output logic      [15:0] termCurrent
);

    // Fast charge current in 0.1 mA units
    logic [15:0] chargeCurrent;

    // Divide and clamp into the legal termination range
    function automatic logic [15:0] clampDiv(input logic [15:0] cur, input logic [15:0] div);
        logic [15:0] q;
        q = cur / div;
        if (q < `CTS_TERM_MIN) begin
            clampDiv = `CTS_TERM_MIN;
        end else if (q > `CTS_TERM_MAX) begin
            clampDiv = `CTS_TERM_MAX;
        end else begin
            clampDiv = q;
        end
    endfunction : clampDiv

    // Fast charge code converted to current
    assign chargeCurrent = 16'(`CTS_ICHG_BASE + 16'(fastChargeCurrentCode) * `CTS_ICHG_STEP);

    // Priority select: /20, then /10, then /5, then the code table
    always_comb begin
        if (ratioDiv20) begin
            termCurrent = clampDiv(chargeCurrent, `CTS_DIV20);  // [RL2]
        end else if (ratioDiv10) begin
            termCurrent = clampDiv(chargeCurrent, `CTS_DIV10);  // [RL3]
        end else if (ratioDiv5) begin
            termCurrent = clampDiv(chargeCurrent, `CTS_DIV5);   // [RL4]
        end else begin
            // Code alone sets the current [RL5]
            case (termCurrentCode)
                3'h0:    termCurrent = `CTS_TERM_C0;  // [RL1]
                3'h1:    termCurrent = `CTS_TERM_C1;
                3'h2:    termCurrent = `CTS_TERM_C2;
                3'h3:    termCurrent = `CTS_TERM_C3;
                3'h4:    termCurrent = `CTS_TERM_C4;
                3'h5:    termCurrent = `CTS_TERM_C5;
                3'h6:    termCurrent = `CTS_TERM_C6;
                default: termCurrent = `CTS_TERM_C7;
            endcase
        end
    end

endmodule : cts_term_calc

// *** rtl/cts_top.sv ***
`timescale 1ns/100ps
`include "cts_cfg.svh"

// Notes on behaviour
// RL1 - Code selects 12.5 to 170 mA; default 010
// RL2 - Divide-by-20 ratio wins, clamped 12.5-170 mA
// RL3 - Divide-by-10 next, clamped 12.5-170 mA
// RL4 - Divide-by-5 next, clamped 12.5-170 mA
// RL5 - No ratio bit: three-bit code alone
// RL6 - Mode 00: enable when regulator and system ok
// RL7 - Mode 01: enable from battery node voltage
// RL8 - Mode 10: enable; isolate battery below weak
// RL9 - Mode 10 isolation only without input, monitor on
// RL10 - Mode 11: regulator without charge, else weak check
// RL11 - Over 140 C the device shuts off
// RL12 - Restart needs below 110 C and fault cleared
// RL13 - Fault clears by power cycle or write-one

module cts_top (
    // Clock, reset, enable
    input  wire logic        mclk,
    input  wire logic        rst,
    input  wire logic        clkEn,
    // Internal register port behind the serial interface
    input  wire logic        regWrEn,
    input  wire logic        regRdEn,
    input  wire logic [7:0]  regAddr,
    input  wire logic [7:0]  regWrData,
    output logic      [7:0]  regRdData,
    // Charger status
    input  wire logic [4:0]  fastChargeCurrentCode,
    input  wire logic        ldoActive,
    input  wire logic        systemVoltageOk,
    input  wire logic        chargeEnable,
    input  wire logic        batteryNodeAboveWeak,
    input  wire logic        inputSupplyZero,
    input  wire logic        inputSupplyPowerCycle,
    input  wire logic        batteryMonitorEnable,
    // Thermal comparators
    input  wire logic        dieAbove140,
    input  wire logic        dieBelow110,
    // Outputs to the charger
    output logic      [15:0] termCurrent,
    output logic             systemEnableOutput,
    output logic             isoSwitchDisable,
    output logic             deviceShutdown
);

    // ==========================================================
    // Storage
    logic [7:0]                  termCfg_q;        // Termination and sysen configuration
    logic                        upperOtFault_q;   // Upper overtemperature fault flag
    cts_pkg::cts_therm_state_t   thermState_q;     // Running or shut down
    logic                        isoLatched_q;     // Battery isolation latched off
    logic [15:0]                 termCurrentNext;  // Decoded termination current
    cts_pkg::cts_sysen_mode_t    sysenMode;        // Mode field as enum
    logic                        sysEnable_d;      // Next system enable
    logic                        isoArmed;         // Mode 10 isolation conditions met
    logic                        cfgWrite;         // Write to configuration register
    logic                        faultWrite;       // Write to fault register

    assign cfgWrite   = clkEn && regWrEn && (regAddr == `CTS_ADDR_TERMCFG);
    assign faultWrite = clkEn && regWrEn && (regAddr == `CTS_ADDR_FAULT);
    assign sysenMode  = cts_pkg::cts_sysen_mode_t'(termCfg_q[`CTS_MODE_MSB:`CTS_MODE_LSB]);

    // ==========================================================
    // Configuration register
    always_ff @(posedge mclk) begin
        if (rst) begin
            termCfg_q <= `CTS_TERMCFG_RESET;  // [RL1]
        end else if (cfgWrite) begin
            termCfg_q <= regWrData;
        end
    end

    // ==========================================================
    // Read data, registered on a read strobe
    always_ff @(posedge mclk) begin
        if (rst) begin
            regRdData <= 8'h00;
        end else if (clkEn && regRdEn) begin
            case (regAddr)
                `CTS_ADDR_TERMCFG: regRdData <= termCfg_q;
                `CTS_ADDR_FAULT:   regRdData <= {7'h00, upperOtFault_q};
                default:           regRdData <= 8'h00;
            endcase
        end
    end

    // ==========================================================
    // Termination current decode
    cts_term_calc u_term_calc (
        .termCurrentCode       (termCfg_q[`CTS_CODE_MSB:`CTS_CODE_LSB]),
        .ratioDiv20            (termCfg_q[`CTS_BIT_DIV20]),
        .ratioDiv10            (termCfg_q[`CTS_BIT_DIV10]),
        .ratioDiv5             (termCfg_q[`CTS_BIT_DIV5]),
        .fastChargeCurrentCode (fastChargeCurrentCode),
        .termCurrent           (termCurrentNext)
    );

    // Registered termination current
    always_ff @(posedge mclk) begin
        if (rst) begin
            termCurrent <= `CTS_TERM_C2;
        end else if (clkEn) begin
            termCurrent <= termCurrentNext;  // [RL2] [RL3] [RL4] [RL5]
        end
    end

    // ==========================================================
    // Upper overtemperature fault flag; a set beats a clear
    always_ff @(posedge mclk) begin
        if (rst) begin
            upperOtFault_q <= 1'b0;
        end else if (clkEn) begin
            if (dieAbove140) begin
                upperOtFault_q <= 1'b1;  // [RL11]
            end else if (inputSupplyPowerCycle) begin
                upperOtFault_q <= 1'b0;  // [RL13]
            end else if (faultWrite && regWrData[`CTS_BIT_UPPER_OT]) begin
                upperOtFault_q <= 1'b0;  // [RL13]
            end
        end
    end

    // ==========================================================
    // Thermal shutdown state machine
    always_ff @(posedge mclk) begin
        if (rst) begin
            thermState_q <= cts_pkg::CTS_THERM_RUN;
        end else if (clkEn) begin
            case (thermState_q)
                cts_pkg::CTS_THERM_RUN: begin
                    if (dieAbove140) begin
                        thermState_q <= cts_pkg::CTS_THERM_SHUTDOWN;  // [RL11]
                    end
                end
                cts_pkg::CTS_THERM_SHUTDOWN: begin
                    // Both cool die and cleared flag are needed
                    if (dieBelow110 && !upperOtFault_q && !dieAbove140) begin
                        thermState_q <= cts_pkg::CTS_THERM_RUN;  // [RL12]
                    end
                end
                default: begin
                    thermState_q <= cts_pkg::CTS_THERM_SHUTDOWN;
                end
            endcase
        end
    end

    // Shutdown output follows the state
    always_ff @(posedge mclk) begin
        if (rst) begin
            deviceShutdown <= 1'b0;
        end else if (clkEn) begin
            deviceShutdown <= (thermState_q == cts_pkg::CTS_THERM_SHUTDOWN) || dieAbove140;  // [RL11]
        end
    end

    // ==========================================================
    // Mode 10 isolation: only with no input and monitor enabled
    assign isoArmed = (sysenMode == cts_pkg::CTS_SYSEN_WEAK_ISO)
                      && inputSupplyZero && batteryMonitorEnable;  // [RL9]

    // Latch isolation once the battery drops below weak
    always_ff @(posedge mclk) begin
        if (rst) begin
            isoLatched_q <= 1'b0;
        end else if (clkEn) begin
            if (!isoArmed) begin
                isoLatched_q <= 1'b0;
            end else if (!batteryNodeAboveWeak) begin
                isoLatched_q <= 1'b1;  // [RL8]
            end
        end
    end

    // Isolation switch drive
    always_ff @(posedge mclk) begin
        if (rst) begin
            isoSwitchDisable <= 1'b0;
        end else if (clkEn) begin
            isoSwitchDisable <= isoArmed && (isoLatched_q || !batteryNodeAboveWeak);  // [RL8]
        end
    end

    // ==========================================================
    // System enable mode decode
    always_comb begin
        case (sysenMode)
            cts_pkg::CTS_SYSEN_LDO_OK: begin
                sysEnable_d = ldoActive && systemVoltageOk;  // [RL6]
            end
            cts_pkg::CTS_SYSEN_BATT_NODE: begin
                sysEnable_d = batteryNodeAboveWeak;  // [RL7]
            end
            cts_pkg::CTS_SYSEN_WEAK_ISO: begin
                sysEnable_d = 1'b1;  // [RL8]
            end
            cts_pkg::CTS_SYSEN_LDO_OR_WEAK: begin
                // Regulator mode without charging, else weak check
                sysEnable_d = chargeEnable ? batteryNodeAboveWeak : ldoActive;  // [RL10]
            end
            default: begin
                sysEnable_d = 1'b0;
            end
        endcase
    end

    // Registered system enable, dropped in shutdown
    always_ff @(posedge mclk) begin
        if (rst) begin
            systemEnableOutput <= 1'b0;
        end else if (clkEn) begin
            // A hot die drops the enable at once, not one cycle after the state moves
            systemEnableOutput <= sysEnable_d && (thermState_q == cts_pkg::CTS_THERM_RUN)
                                  && !dieAbove140;  // [RL11]
        end
    end

endmodule : cts_top

// *** dv/cts_top_checker.sv ***
`timescale 1ns/100ps

// ==========================================================
// Port checker for the termination and system-enable block
module cts_top_checker (
    // Clock and reset
    input wire logic        mclk,
    input wire logic        rst,
    input wire logic        clkEn,
    // Register port
    input wire logic        regWrEn,
    input wire logic        regRdEn,
    input wire logic [7:0]  regAddr,
    input wire logic [7:0]  regWrData,
    input wire logic [7:0]  regRdData,
    // Status inputs
    input wire logic        ldoActive,
    input wire logic        systemVoltageOk,
    input wire logic        chargeEnable,
    input wire logic        batteryNodeAboveWeak,
    input wire logic        inputSupplyZero,
    input wire logic        batteryMonitorEnable,
    input wire logic        dieAbove140,
    input wire logic        dieBelow110,
    // Outputs under watch
    input wire logic [15:0] termCurrent,
    input wire logic        systemEnableOutput,
    input wire logic        isoSwitchDisable,
    input wire logic        deviceShutdown
);
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    logic [7:0] cfg_q;   // Shadow of the configuration register
    logic       live_q;  // Last edge was a normal enabled edge
    // Shadow follows taken config writes; live flag masks reset edges
    always_ff @(posedge mclk) begin
        if (rst) begin
            cfg_q <= 8'h40;
        end else if (clkEn && regWrEn && regAddr == 8'h11) begin
            cfg_q <= regWrData;
        end
        live_q <= !rst && clkEn;
    end
    AST_RESET_TERM: assert property ($past(rst) |-> termCurrent == 16'd525)
        else $error("termCurrent not at default after reset");
    AST_READ_CFG: assert property (live_q && $past(regRdEn && regAddr == 8'h11) |-> regRdData == $past(cfg_q))
        else $error("config readback wrong");
    AST_TERM_RANGE: assert property (termCurrent >= 16'd125 && termCurrent <= 16'd1700)
        else $error("termCurrent outside clamp range");
    AST_MODE_00: assert property (live_q && !deviceShutdown && $past(cfg_q[1:0]) == 2'h0
        |-> systemEnableOutput == $past(ldoActive && systemVoltageOk)) else $error("mode 00 enable wrong");
    AST_MODE_01: assert property (live_q && !deviceShutdown && $past(cfg_q[1:0]) == 2'h1
        |-> systemEnableOutput == $past(batteryNodeAboveWeak)) else $error("mode 01 enable wrong");
    AST_MODE_10: assert property (live_q && !deviceShutdown && $past(cfg_q[1:0]) == 2'h2
        |-> systemEnableOutput) else $error("mode 10 enable low");
    AST_MODE_11: assert property (live_q && !deviceShutdown && $past(cfg_q[1:0]) == 2'h3
        |-> systemEnableOutput == $past(chargeEnable ? batteryNodeAboveWeak : ldoActive))
        else $error("mode 11 enable wrong");
    AST_ISO_ARMED: assert property (live_q && isoSwitchDisable
        |-> $past(cfg_q[1:0]) == 2'h2 && $past(inputSupplyZero && batteryMonitorEnable))
        else $error("isolation off while unarmed");
    AST_HOT_SHUT: assert property (live_q && $past(dieAbove140) |-> deviceShutdown && !systemEnableOutput)
        else $error("no shutdown when hot");
    AST_STAY_SHUT: assert property (deviceShutdown && !dieBelow110 && $past(!dieBelow110) |=> deviceShutdown)
        else $error("restart while die still warm");
    // Main scenarios reached
    cover property (deviceShutdown ##1 !deviceShutdown);
    cover property (isoSwitchDisable);
    cover property (live_q && $past(regWrEn && regAddr == 8'h0d));
endmodule : cts_top_checker

bind cts_top cts_top_checker u_checker (.*);

// *** dv/cts_host_model.sv ***
`timescale 1ns/100ps

// ==========================================================
// Host model on the block's register port
module cts_host_model (
    // Clock
    input wire logic        mclk,
    // Register port
    output logic            regWrEn,
    output logic            regRdEn,
    output logic      [7:0] regAddr,
    output logic      [7:0] regWrData,
    input wire logic  [7:0] regRdData
);
    // Idle port at time zero
    initial begin
        regWrEn = 1'b0;
        regRdEn = 1'b0;
        regAddr = 8'h00;
        regWrData = 8'h00;
    end
    // One-byte write; released lines stop showing the old byte
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge mclk);
        regWrEn <= 1'b1;
        regAddr <= a;
        regWrData <= d;
        @(posedge mclk);
        regWrEn <= 1'b0;
        regAddr <= ~a;
        regWrData <= ~d;
    endtask : wr
    // One-byte read; data settles just after the taking edge
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        @(posedge mclk);
        regRdEn <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRdEn <= 1'b0;
        regAddr <= ~a;
        #1 d = regRdData;
    endtask : rd
    // Clear the upper overtemperature fault by writing a one
    task automatic clrFault;
        wr(8'h0d, 8'h01);
    endtask : clrFault
endmodule : cts_host_model

// *** dv/test_charge_termination_sysen_select.sv ***
`timescale 1ns/100ps
`include "cts_cfg.svh"

// ==========================================================
// Bench: reference model checked at every result
module test_charge_termination_sysen_select;
    logic       mclk = 1'b0, rst = 1'b1, clkEn = 1'b1;
    logic       regWrEn, regRdEn;
    logic [7:0] regAddr, regWrData, regRdData, rd8, cfg;
    logic [4:0] fastChargeCurrentCode = 5'h00;
    logic       ldoActive = 1'b0, systemVoltageOk = 1'b0, chargeEnable = 1'b0;
    logic       batteryNodeAboveWeak = 1'b0, inputSupplyZero = 1'b0, inputSupplyPowerCycle = 1'b0;
    logic       batteryMonitorEnable = 1'b0, dieAbove140 = 1'b0, dieBelow110 = 1'b1;
    logic [15:0] termCurrent;
    logic       systemEnableOutput, isoSwitchDisable, deviceShutdown;
    int         numErrors = 0, nTests = 0, cycles = 0;
    logic [7:0] expQ[$];  // Written config bytes awaiting readback
    // Design and host
    cts_top u_dut (.*);
    cts_host_model u_host (.*);
    // 250 MHz clock
    always #2 mclk = ~mclk;
    // Hang guard
    always @(posedge mclk) begin
        cycles++;
        if (cycles == 5000) begin
            numErrors++;
            complete_run();
        end
    end
    // Expected end-of-charge current, 0.1 mA units
    function automatic int expTerm(input logic [7:0] c, input int code);
        int tbl[8] = '{125, 325, 525, 725, 925, 1175, 1425, 1700};
        int ich;
        int v;
        ich = `CTS_ICHG_BASE + code * `CTS_ICHG_STEP;
        v = c[4] ? ich / 20 : c[3] ? ich / 10 : c[2] ? ich / 5 : tbl[c[7:5]];
        return (v < 125) ? 125 : (v > 1700) ? 1700 : v;
    endfunction : expTerm
    // Expected system enable by mode
    function automatic logic expSys(input logic [7:0] c);
        case (c[1:0])
            2'h0: return ldoActive && systemVoltageOk;
            2'h1: return batteryNodeAboveWeak;
            2'h2: return 1'b1;
            default: return chargeEnable ? batteryNodeAboveWeak : ldoActive;
        endcase
    endfunction : expSys
    // Compare and count
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        nTests++;
        if (g !== e) begin
            numErrors++;
            $display("FAIL %s expected %h seen %h", nm, e, g);
        end
    endtask : chk
    // Let n edges pass, then settle
    task automatic waitc(input int n);
        repeat (n) @(posedge mclk);
        #1;
    endtask : waitc
    // Verdict and end
    task automatic complete_run;
        $display("Comparisons %0d, mismatches %0d", nTests, numErrors);
        if (numErrors == 0 && nTests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    // Main sequence
    initial begin
        cycles = $urandom(32'hfd12);
        cycles = 0;
        repeat (6) @(posedge mclk);
        rst <= 1'b0;
        waitc(1);
        // Defaults, fault register, unmapped place
        chk("termDefault", 16'd525, termCurrent);
        u_host.rd(8'h11, rd8);
        chk("cfgDefault", 16'h40, rd8);
        u_host.rd(8'h0d, rd8);
        chk("faultDefault", 16'h00, rd8);
        u_host.wr(8'h20, 8'hff);
        u_host.rd(8'h20, rd8);
        chk("unmapped", 16'h00, rd8);
        // Every code, then random settings and inputs
        for (int i = 0; i < 48; i++) begin
            cfg = (i < 8) ? {i[2:0], 5'h00} : 8'($urandom);
            @(posedge mclk);
            {fastChargeCurrentCode, ldoActive, systemVoltageOk, chargeEnable, batteryNodeAboveWeak,
             inputSupplyZero, batteryMonitorEnable} <= 11'($urandom);
            u_host.wr(8'h11, cfg);
            expQ.push_back(cfg);
            waitc(3);
            chk("term", 16'(expTerm(cfg, fastChargeCurrentCode)), termCurrent);
            chk("sysen", 16'(expSys(cfg)), systemEnableOutput);
            u_host.rd(8'h11, rd8);
            chk("cfgRead", 16'(expQ.pop_front()), rd8);
        end
        // Isolation latches below weak while armed
        u_host.wr(8'h11, 8'h42);
        @(posedge mclk);
        {inputSupplyZero, batteryMonitorEnable, batteryNodeAboveWeak} <= 3'b110;
        waitc(3);
        chk("isoSet", 16'h1, isoSwitchDisable);
        @(posedge mclk);
        batteryNodeAboveWeak <= 1'b1;
        waitc(3);
        chk("isoHeld", 16'h1, isoSwitchDisable);
        @(posedge mclk);
        batteryMonitorEnable <= 1'b0;
        waitc(3);
        chk("isoDisarm", 16'h0, isoSwitchDisable);
        // Overtemperature, wrong clear, proper clear
        @(posedge mclk);
        {dieAbove140, dieBelow110} <= 2'b10;
        waitc(2);
        chk("shut", 16'h1, deviceShutdown);
        chk("shutSysen", 16'h0, systemEnableOutput);
        u_host.rd(8'h0d, rd8);
        chk("faultSet", 16'h01, rd8);
        @(posedge mclk);
        {dieAbove140, dieBelow110} <= 2'b01;
        u_host.wr(8'h0d, 8'h00);
        waitc(6);
        chk("stayShut", 16'h1, deviceShutdown);
        u_host.clrFault();
        waitc(4);
        chk("restart", 16'h0, deviceShutdown);
        chk("restartSysen", 16'h1, systemEnableOutput);
        // Fault cleared by input power cycle
        @(posedge mclk);
        dieAbove140 <= 1'b1;
        @(posedge mclk);
        dieAbove140 <= 1'b0;
        inputSupplyPowerCycle <= 1'b1;
        @(posedge mclk);
        inputSupplyPowerCycle <= 1'b0;
        waitc(2);
        u_host.rd(8'h0d, rd8);
        chk("faultCycle", 16'h00, rd8);
        // Clock enable low: a write must not land
        @(posedge mclk);
        clkEn <= 1'b0;
        u_host.wr(8'h11, 8'h1f);
        clkEn <= 1'b1;
        u_host.rd(8'h11, rd8);
        chk("frozenCfg", 16'h42, rd8);
        // Reset in mid-run returns the defaults; first read taken on the second edge after release
        @(posedge mclk);
        rst <= 1'b1;
        repeat (2) @(posedge mclk);
        rst <= 1'b0;
        u_host.rd(8'h11, rd8);
        chk("cfgReset", 16'h40, rd8);
        chk("termReset", 16'd525, termCurrent);
        chk("shutReset", 16'h0, deviceShutdown);
        complete_run();
    end
endmodule : test_charge_termination_sysen_select
